// ### verilog/dop_alu_pkg.sv
// constants, field layout and register map of the two-operand execution datapath
package dop_alu_pkg;
  localparam int          DATA_W     = 16;
  localparam int          BYTE_W     = 8;
  localparam int          SPEC_W     = 6;
  localparam int          FIELD_W    = 3;
  localparam int          FLAG_W     = 4;
  localparam int          RADDR_W    = 4;

  // instruction word layout
  localparam int          BYTE_BIT   = 15;
  localparam int          OP_HI      = 14;
  localparam int          OP_LO      = 12;
  localparam int          SRC_HI     = 11;
  localparam int          SRC_LO     = 6;
  localparam int          DST_HI     = 5;
  localparam int          DST_LO     = 0;
  localparam int          MODE_HI    = 5;
  localparam int          MODE_LO    = 3;
  localparam int          REG_HI     = 2;
  localparam int          REG_LO     = 0;

  // operation codes in the op field
  localparam logic [2:0]  OPC_COPY   = 3'h1;
  localparam logic [2:0]  OPC_CMP    = 3'h2;
  localparam logic [2:0]  OPC_BIT    = 3'h3;
  localparam logic [2:0]  OPC_BIC    = 3'h4;
  localparam logic [2:0]  OPC_BIS    = 3'h5;
  localparam logic [2:0]  OPC_ADDSUB = 3'h6;

  // condition flag positions in the status word
  localparam int          FLAG_C     = 0;
  localparam int          FLAG_V     = 1;
  localparam int          FLAG_Z     = 2;
  localparam int          FLAG_N     = 3;

  // register port map (word index)
  localparam logic [3:0]  REG_FLAGS  = 4'h0;
  localparam logic [3:0]  REG_RESULT = 4'h1;
  localparam logic [3:0]  REG_COUNT  = 4'h2;

  localparam logic [3:0]  FLAGS_RST  = 4'h0;
  localparam logic [15:0] WORD_ZERO  = 16'h0000;
  localparam logic [7:0]  BYTE_ZERO  = 8'h00;
  localparam logic [16:0] ONE_17     = 17'h00001;

  typedef enum logic [2:0] {
    ALU_NONE,
    ALU_COPY,
    ALU_CMP,
    ALU_BIT,
    ALU_BIC,
    ALU_BIS,
    ALU_ADD,
    ALU_SUB
  } alu_op_t;
endpackage

// ### verilog/double_operand_alu.sv
// two-operand execution datapath: copy, compare, bit test/clear/set, add, subtract
//
// How it works
// [RULE1] copy writes source into destination
// [RULE2] byte copy to register sign-extends
// [RULE3] copy flags: N,Z from source, V cleared
// [RULE4] compare adds source, inverted destination, one
// [RULE5] compare sets N and Z from result
// [RULE6] compare overflow: opposite signs, dest matches
// [RULE7] compare carry cleared on carry out
// [RULE8] bit test ANDs, flags only
// [RULE9] bit clear stores inverted source AND dest
// [RULE10] bit set stores source OR dest
// [RULE11] logic ops: N,Z from result, V cleared
// [RULE12] add stores two's complement sum
// [RULE13] add overflow: same signs, result differs
// [RULE14] add carry from msb, Z on zero
// [RULE15] subtract stores dest plus inverted source plus one
// [RULE16] subtract sets N and Z from result
// [RULE17] subtract overflow: opposite signs, source matches
// [RULE18] subtract carry set means borrow
// [RULE19] low field selects destination mode, register
// [RULE20] next field selects source mode, register
// [RULE21] byte ops work on low byte only
// [RULE22] flags kept in status word per instruction
//
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/10ps
module double_operand_alu
  import dop_alu_pkg::*;
(
  input  wire logic                         i_clk_sys,
  input  wire logic                         i_rst_n,
  input  wire logic                         i_start,
  input  wire logic [dop_alu_pkg::DATA_W-1:0]  i_instr,
  input  wire logic [dop_alu_pkg::DATA_W-1:0]  i_src,
  input  wire logic [dop_alu_pkg::DATA_W-1:0]  i_dst,
  input  wire logic                         i_dst_is_reg,
  input  wire logic [dop_alu_pkg::RADDR_W-1:0] i_reg_addr,
  input  wire logic [dop_alu_pkg::DATA_W-1:0]  i_reg_wdata,
  input  wire logic                         i_reg_wr,
  input  wire logic                         i_reg_rd,
  output logic      [dop_alu_pkg::DATA_W-1:0]  o_reg_rdata,
  output logic                              o_done,
  output logic                              o_not_in_group,
  output logic                              o_dst_write,
  output logic                              o_byte_write,
  output logic      [dop_alu_pkg::DATA_W-1:0]  o_result,
  output logic      [dop_alu_pkg::FIELD_W-1:0] o_src_mode,
  output logic      [dop_alu_pkg::FIELD_W-1:0] o_src_reg,
  output logic      [dop_alu_pkg::FIELD_W-1:0] o_dst_mode,
  output logic      [dop_alu_pkg::FIELD_W-1:0] o_dst_reg,
  output logic                              o_flag_n,
  output logic                              o_flag_z,
  output logic                              o_flag_v,
  output logic                              o_flag_c
);
  import dop_alu_pkg::*;

  logic [DATA_W-1:0] last_result;
  logic [DATA_W-1:0] exec_count;
  logic [SPEC_W-1:0] src_spec;
  logic [SPEC_W-1:0] dst_spec;
  logic [2:0]        op_field;
  logic              is_byte;
  alu_op_t           alu_op;
  logic              in_group;
  logic [DATA_W-1:0] src_al;
  logic [DATA_W-1:0] dst_al;
  logic [DATA_W:0]   sum;
  logic [DATA_W-1:0] res_al;
  logic [BYTE_W-1:0] res_byte;
  logic [DATA_W-1:0] next_result;
  logic              next_write;
  logic              next_v;
  logic              next_c;
  logic              next_n;
  logic              next_z;
  logic              take;

  // map op field and byte bit onto an operation
  function automatic alu_op_t decode_op(input logic [2:0] op, input logic byte_form);
    alu_op_t r;
    r = ALU_NONE;
    case (op)
      OPC_COPY:   r = ALU_COPY;
      OPC_CMP:    r = ALU_CMP;
      OPC_BIT:    r = ALU_BIT;
      OPC_BIC:    r = ALU_BIC;
      OPC_BIS:    r = ALU_BIS;
      OPC_ADDSUB: r = byte_form ? ALU_SUB : ALU_ADD;
      default:    r = ALU_NONE;
    endcase
    return r;
  endfunction

  // instruction fields
  // [RULE19] destination field split
  // [RULE20] source field split
  assign dst_spec = i_instr[DST_HI:DST_LO];
  assign src_spec = i_instr[SRC_HI:SRC_LO];
  assign op_field = i_instr[OP_HI:OP_LO];
  assign is_byte  = i_instr[BYTE_BIT] && (op_field != OPC_ADDSUB);
  assign alu_op   = decode_op(op_field, i_instr[BYTE_BIT]);
  assign in_group = (alu_op != ALU_NONE);
  assign take     = i_start && in_group;

  // [RULE21] byte operands aligned to the top byte
  // keeps one msb, one carry and one zero test for both widths
  assign src_al = is_byte ? {i_src[BYTE_W-1:0], BYTE_ZERO} : i_src;
  assign dst_al = is_byte ? {i_dst[BYTE_W-1:0], BYTE_ZERO} : i_dst;

  // the arithmetic and logic core
  always_comb
  begin
    sum        = {1'b0, WORD_ZERO};
    res_al     = WORD_ZERO;
    next_write = 1'b0;
    next_v     = 1'b0;
    next_c     = o_flag_c;
    case (alu_op)
      ALU_COPY:
      begin
        // [RULE1] source to destination
        res_al     = src_al;
        next_write = 1'b1;
      end
      ALU_CMP:
      begin
        // [RULE4] source plus inverted destination plus one
        // inverted pad of ones lets the +1 ripple into the byte
        sum    = {1'b0, src_al} + {1'b0, ~dst_al} + ONE_17;
        res_al = sum[DATA_W-1:0];
        // [RULE6] compare overflow
        next_v = (src_al[DATA_W-1] != dst_al[DATA_W-1]) && (dst_al[DATA_W-1] == res_al[DATA_W-1]);
        // [RULE7] compare carry inverted
        next_c = ~sum[DATA_W];
      end
      ALU_BIT:
      begin
        // [RULE8] and without write back
        res_al = src_al & dst_al;
      end
      ALU_BIC:
      begin
        // [RULE9] clear source bits
        res_al     = ~src_al & dst_al;
        next_write = 1'b1;
      end
      ALU_BIS:
      begin
        // [RULE10] inclusive or
        res_al     = src_al | dst_al;
        next_write = 1'b1;
      end
      ALU_ADD:
      begin
        // [RULE12] two's complement sum
        sum        = {1'b0, src_al} + {1'b0, dst_al};
        res_al     = sum[DATA_W-1:0];
        next_write = 1'b1;
        // [RULE13] add overflow
        next_v = (src_al[DATA_W-1] == dst_al[DATA_W-1]) && (res_al[DATA_W-1] != src_al[DATA_W-1]);
        // [RULE14] add carry out
        next_c = sum[DATA_W];
      end
      ALU_SUB:
      begin
        // [RULE15] destination plus inverted source plus one
        sum        = {1'b0, dst_al} + {1'b0, ~src_al} + ONE_17;
        res_al     = sum[DATA_W-1:0];
        next_write = 1'b1;
        // [RULE17] subtract overflow
        next_v = (src_al[DATA_W-1] != dst_al[DATA_W-1]) && (src_al[DATA_W-1] == res_al[DATA_W-1]);
        // [RULE18] set carry means borrow
        next_c = ~sum[DATA_W];
      end
      default:
      begin
        res_al = WORD_ZERO;
      end
    endcase
  end

  // [RULE3] [RULE5] [RULE11] [RULE14] [RULE16] n and z from result
  // v and c come from the core; logic ops and copy keep c
  assign next_n = res_al[DATA_W-1];
  assign next_z = (res_al == WORD_ZERO);

  // word handed back to the destination path
  assign res_byte = res_al[DATA_W-1:DATA_W-BYTE_W];
  always_comb
  begin
    next_result = res_al;
    if (is_byte)
    begin
      if (alu_op == ALU_COPY && i_dst_is_reg)
      begin
        // [RULE2] sign extension on byte copy to register
        next_result = {{BYTE_W{res_byte[BYTE_W-1]}}, res_byte};
      end
      else
      begin
        // [RULE21] upper byte untouched
        next_result = {i_dst[DATA_W-1:BYTE_W], res_byte};
      end
    end
  end

  // instruction handshake and result outputs
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_done         <= 1'b0;
      o_not_in_group <= 1'b0;
      o_dst_write    <= 1'b0;
      o_byte_write   <= 1'b0;
      o_result       <= WORD_ZERO;
    end
    else
    begin
      o_done         <= take;
      o_not_in_group <= i_start && !in_group;
      o_dst_write    <= take && next_write;
      o_byte_write   <= take && next_write && is_byte && !i_dst_is_reg;
      if (take)
      begin
        o_result <= next_result;
      end
    end
  end

  // operand specifiers held for the fetch logic
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_src_mode <= 3'h0;
      o_src_reg  <= 3'h0;
      o_dst_mode <= 3'h0;
      o_dst_reg  <= 3'h0;
    end
    else if (i_start)
    begin
      // [RULE19] destination mode and register
      o_dst_mode <= dst_spec[MODE_HI:MODE_LO];
      o_dst_reg  <= dst_spec[REG_HI:REG_LO];
      // [RULE20] source mode and register
      o_src_mode <= src_spec[MODE_HI:MODE_LO];
      o_src_reg  <= src_spec[REG_HI:REG_LO];
    end
  end

  // [RULE22] status word flags
  // an instruction ending wins over a software write in the same cycle
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_flag_n <= FLAGS_RST[FLAG_N];
      o_flag_z <= FLAGS_RST[FLAG_Z];
      o_flag_v <= FLAGS_RST[FLAG_V];
      o_flag_c <= FLAGS_RST[FLAG_C];
    end
    else if (take)
    begin
      o_flag_n <= next_n;
      o_flag_z <= next_z;
      o_flag_v <= next_v;
      o_flag_c <= next_c;
    end
    else if (i_reg_wr && i_reg_addr == REG_FLAGS)
    begin
      o_flag_n <= i_reg_wdata[FLAG_N];
      o_flag_z <= i_reg_wdata[FLAG_Z];
      o_flag_v <= i_reg_wdata[FLAG_V];
      o_flag_c <= i_reg_wdata[FLAG_C];
    end
  end

  // last result and executed-instruction count, visible to software
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      last_result <= WORD_ZERO;
      exec_count  <= WORD_ZERO;
    end
    else if (take)
    begin
      last_result <= next_result;
      exec_count  <= exec_count + 16'h0001;
    end
    else if (i_reg_wr && i_reg_addr == REG_COUNT)
    begin
      exec_count <= i_reg_wdata;
    end
  end

  // read port, data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_reg_rdata <= WORD_ZERO;
    end
    else if (i_reg_rd)
    begin
      case (i_reg_addr)
        REG_FLAGS:  o_reg_rdata <= {12'h000, o_flag_n, o_flag_z, o_flag_v, o_flag_c};
        REG_RESULT: o_reg_rdata <= last_result;
        REG_COUNT:  o_reg_rdata <= exec_count;
        default:    o_reg_rdata <= WORD_ZERO;
      endcase
    end
    else
    begin
      o_reg_rdata <= WORD_ZERO;
    end
  end

  // [RULE1] copy checks
  a_copy_word_value: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // [RULE1]
    (i_start && alu_op == ALU_COPY && !is_byte) |=> (o_dst_write && o_result == $past(i_src) && !o_flag_v))
    else $error("word copy did not store source");

  // [RULE2] sign extension check
  a_copy_byte_sext: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // [RULE2]
    (i_start && alu_op == ALU_COPY && is_byte && i_dst_is_reg)
      |=> (o_result == {{BYTE_W{$past(i_src[BYTE_W-1])}}, $past(i_src[BYTE_W-1:0])}))
    else $error("byte copy to register not sign extended");

  // [RULE4] compare leaves operands alone
  a_cmp_no_write: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // [RULE4]
    (i_start && (alu_op == ALU_CMP || alu_op == ALU_BIT)) |=> (o_done && !o_dst_write))
    else $error("compare or bit test wrote destination");

  // [RULE7] compare carry is unsigned less-than
  a_cmp_borrow: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // [RULE7]
    (i_start && alu_op == ALU_CMP && !is_byte) |=> (o_flag_c == ($past(i_src) < $past(i_dst))))
    else $error("compare carry wrong");

  // [RULE5] compare zero on equal words
  a_cmp_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // [RULE5]
    (i_start && alu_op == ALU_CMP && !is_byte) |=> (o_flag_z == ($past(i_src) == $past(i_dst))))
    else $error("compare zero flag wrong");

  // [RULE11] logic ops keep carry and clear overflow
  a_logic_keep_c: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // [RULE11]
    (i_start && (alu_op == ALU_BIT || alu_op == ALU_BIC || alu_op == ALU_BIS))
      |=> (o_flag_c == $past(o_flag_c) && !o_flag_v))
    else $error("logic op disturbed carry or overflow");

  // [RULE14] add carry out
  a_add_carry: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // [RULE14]
    (i_start && alu_op == ALU_ADD) |=> (o_flag_c == ($past(i_src) > (16'hffff - $past(i_dst)))))
    else $error("add carry wrong");

  // [RULE15] subtract value
  a_sub_value: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // [RULE15]
    (i_start && alu_op == ALU_SUB) |=> (o_dst_write && o_result == 16'($past(i_dst) - $past(i_src))))
    else $error("subtract result wrong");

  // [RULE21] byte ops other than copy keep destination upper byte
  a_byte_upper_kept: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // [RULE21]
    (i_start && is_byte && alu_op != ALU_COPY && in_group)
      |=> (o_result[DATA_W-1:BYTE_W] == $past(i_dst[DATA_W-1:BYTE_W])))
    else $error("byte op changed upper byte");

  // [RULE19] destination specifier latched
  a_dst_fields: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // [RULE19]
    i_start |=> ({o_dst_mode, o_dst_reg} == $past(i_instr[DST_HI:DST_LO])))
    else $error("destination specifier not decoded");
endmodule

// ### bench/operand_feeder.sv
// operand fetch model: presents an instruction with its operands for one cycle
`timescale 1ns/10ps
module operand_feeder
(
  input  wire logic        i_clk,
  output logic             o_start,
  output logic [15:0]      o_instr,
  output logic [15:0]      o_src,
  output logic [15:0]      o_dst,
  output logic             o_dst_is_reg
);
  initial
  begin
    o_start      = 1'b0;
    o_instr      = 16'h0000;
    o_src        = 16'h0000;
    o_dst        = 16'h0000;
    o_dst_is_reg = 1'b0;
  end

  // one request, then operands scrambled so a late sample shows up as wrong data
  task automatic issue(input logic [15:0] ins, s, d, input logic isr);
    @(posedge i_clk);
    o_start      <= 1'b1;
    o_instr      <= ins;
    o_src        <= s;
    o_dst        <= d;
    o_dst_is_reg <= isr;
    @(posedge i_clk);
    o_start      <= 1'b0;
    o_instr      <= ~ins;
    o_src        <= ~s;
    o_dst        <= ~d;
    o_dst_is_reg <= ~isr;
  endtask
endmodule

// ### bench/tb_top.sv
// self-checking bench for the two-operand execution datapath
`timescale 1ns/10ps
module tb_top;
  import dop_alu_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        start, isreg, done, nig, dw, bw, fn, fz, fv, fc;
  logic [15:0] instr, src, dst, rdata, result;
  logic [2:0]  sm, sr, dm, dr;
  logic [3:0]  ef = 4'h0;
  logic [15:0] er = 16'h0000;
  logic [15:0] cnt = 16'h0000;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  int          cyc = 0;

  // 50 MHz system clock
  always #10 clk = ~clk;

  operand_feeder fb (.i_clk(clk), .o_start(start), .o_instr(instr), .o_src(src), .o_dst(dst), .o_dst_is_reg(isreg));

  double_operand_alu uut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_start(start), .i_instr(instr), .i_src(src),
    .i_dst(dst), .i_dst_is_reg(isreg), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr),
    .i_reg_rd(reg_rd), .o_reg_rdata(rdata), .o_done(done), .o_not_in_group(nig), .o_dst_write(dw),
    .o_byte_write(bw), .o_result(result), .o_src_mode(sm), .o_src_reg(sr), .o_dst_mode(dm), .o_dst_reg(dr),
    .o_flag_n(fn), .o_flag_z(fz), .o_flag_v(fv), .o_flag_c(fc));

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // hang guard, far above the length of the sequence
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [15:0] got, exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  function automatic logic [15:0] mk(input logic b, input logic [2:0] op, input logic [5:0] s, d);
    return {b, op, s, d};
  endfunction

  // reference: {n, z, v, c, result}; sub is selected by the byte bit of op 6 and is word wide
  function automatic logic [19:0] exp_of(input logic [15:0] ins, s0, d0, input logic isr, c0);
    logic [2:0]  op;
    logic        byt, n, z, v, c, sg, dg, rg;
    logic [16:0] m, s, d, r;
    op = ins[14:12];
    byt = ins[15] && op != 3'h6;
    m = byt ? 17'h000ff : 17'h0ffff;
    s = {1'b0, s0} & m;
    d = {1'b0, d0} & m;
    v = 1'b0;
    c = c0;
    case (op)
      3'h1: r = s;
      3'h2: r = s + (~d & m) + 17'h00001;
      3'h3: r = s & d;
      3'h4: r = ~s & d;
      3'h5: r = s | d;
      default: r = ins[15] ? d + (~s & m) + 17'h00001 : s + d;
    endcase
    sg = byt ? s[7] : s[15];
    dg = byt ? d[7] : d[15];
    rg = byt ? r[7] : r[15];
    if (op == 3'h2)
    begin
      c = ~(byt ? r[8] : r[16]);
      v = (sg != dg) && (dg == rg);
    end
    if (op == 3'h6)
    begin
      c = ins[15] ? ~r[16] : r[16];
      v = ins[15] ? (sg != dg) && (sg == rg) : (sg == dg) && (rg != sg);
    end
    r = r & m;
    n = rg;
    z = (r == 17'h00000);
    if (byt)
      r[15:8] = (op == 3'h1 && isr) ? {8{r[7]}} : d0[15:8];
    return {n, z, v, c, r[15:0]};
  endfunction

  // one instruction through the partner, then every output but the read port checked in its answer cycle
  task automatic run(input logic [15:0] ins, s, d, input logic isr);
    logic [19:0] e;
    logic        ok, wr;
    ok = ins[14:12] != 3'h0 && ins[14:12] != 3'h7;
    wr = ok && ins[14:12] inside {3'h1, 3'h4, 3'h5, 3'h6};
    e = exp_of(ins, s, d, isr, ef[0]);
    fb.issue(ins, s, d, isr);
    #1;
    if (ok)
    begin
      ef = e[19:16];
      er = e[15:0];
      cnt++;
    end
    chk(16'({done, nig, dw, bw}), 16'({ok, !ok, wr, wr && ins[15] && ins[14:12] != 3'h6 && !isr}), "pulses");
    chk(result, er, "result");
    chk(16'({fn, fz, fv, fc}), 16'(ef), "flags");
    chk(16'({sm, sr, dm, dr}), 16'(ins[11:0]), "fields");
  endtask

  task automatic reg_wr_t(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic reg_rd_t(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    chk(rdata, exp, "register read");
  endtask

  // main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    reg_rd_t(REG_FLAGS, 16'h0000);
    run(mk(1'b0, 3'h1, 6'h0a, 6'h13), 16'h8000, 16'h1234, 1'b0);
    run(mk(1'b1, 3'h1, 6'h11, 6'h05), 16'h0080, 16'h1234, 1'b1);
    run(mk(1'b1, 3'h1, 6'h2c, 6'h1f), 16'h1200, 16'habcd, 1'b0);
    run(mk(1'b0, 3'h2, 6'h3e, 6'h21), 16'h8000, 16'h0001, 1'b0);
    run(mk(1'b0, 3'h2, 6'h01, 6'h3a), 16'h0001, 16'h0002, 1'b0);
    run(mk(1'b1, 3'h2, 6'h17, 6'h02), 16'h007f, 16'h3380, 1'b1);
    run(mk(1'b0, 3'h3, 6'h24, 6'h19), 16'hf0f0, 16'h0f0f, 1'b0);
    run(mk(1'b1, 3'h3, 6'h09, 6'h36), 16'h0080, 16'h00ff, 1'b0);
    run(mk(1'b0, 3'h4, 6'h30, 6'h0c), 16'h00ff, 16'h1234, 1'b0);
    run(mk(1'b1, 3'h4, 6'h12, 6'h04), 16'h000f, 16'h12ab, 1'b1);
    run(mk(1'b0, 3'h5, 6'h3f, 6'h2d), 16'h8000, 16'h0001, 1'b0);
    run(mk(1'b1, 3'h5, 6'h06, 6'h28), 16'h0080, 16'h5500, 1'b0);
    run(mk(1'b0, 3'h6, 6'h1b, 6'h33), 16'h7fff, 16'h0001, 1'b0);
    run(mk(1'b0, 3'h6, 6'h27, 6'h10), 16'hffff, 16'h0001, 1'b0);
    run(mk(1'b1, 3'h6, 6'h0d, 6'h3b), 16'h0002, 16'h0001, 1'b0);
    run(mk(1'b1, 3'h6, 6'h35, 6'h08), 16'h0001, 16'h8000, 1'b0);
    run(mk(1'b0, 3'h0, 6'h14, 6'h2a), 16'h1111, 16'h2222, 1'b0);
    run(mk(1'b1, 3'h7, 6'h2b, 6'h15), 16'h3333, 16'h4444, 1'b0);
    reg_rd_t(REG_FLAGS, 16'(ef));
    reg_rd_t(REG_RESULT, er);
    reg_wr_t(REG_FLAGS, 16'h0001);
    ef = 4'h1;
    reg_rd_t(REG_FLAGS, 16'h0001);
    run(mk(1'b0, 3'h1, 6'h01, 6'h02), 16'h0000, 16'h5a5a, 1'b1);
    run(mk(1'b0, 3'h4, 6'h03, 6'h04), 16'hffff, 16'h8421, 1'b0);
    // flags write in the same cycle as an accepted copy must lose
    fork
      reg_wr_t(REG_FLAGS, 16'h000e);
      run(mk(1'b0, 3'h1, 6'h05, 6'h06), 16'h0001, 16'h0000, 1'b0);
    join
    reg_rd_t(REG_COUNT, cnt);
    reg_wr_t(REG_COUNT, 16'h00a5);
    // result register is read only, a write must be ignored
    reg_wr_t(REG_RESULT, 16'h1111);
    reg_rd_t(REG_COUNT, 16'h00a5);
    reg_rd_t(REG_RESULT, er);
    reg_rd_t(4'h3, 16'h0000);
    // second reset in mid-run clears result, flags and count
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk(result, 16'h0000, "result after reset");
    reg_rd_t(REG_FLAGS, 16'h0000);
    reg_rd_t(REG_COUNT, 16'h0000);
    tally_and_finish();
  end
endmodule
